/* File: hw/gpdr_pkg.sv */
// Package for the two-port GPIO data/direction block.
// Assumes a 32-bit Avalon-MM slave with word addresses derived from bytes.
package gpdr_pkg;

   // Byte addresses of the two port registers
   localparam logic [31:0] GPDR_PORT0_ADDR  = 32'hFFFF0D20;
   localparam logic [31:0] GPDR_PORT1_ADDR  = 32'hFFFF0D30;

   // Local decode: word index within the block window
   localparam int          GPDR_ADDR_W      = 3;
   localparam logic [2:0]  GPDR_PORT0_IDX   = 3'h0;
   localparam logic [2:0]  GPDR_PORT1_IDX   = 3'h4;

   // Pin counts
   localparam int          GPDR_P0_PINS     = 5;
   localparam int          GPDR_P1_PINS     = 2;

   // Field positions (low bit of each field)
   localparam int          GPDR_DIR_LSB     = 24;
   localparam int          GPDR_OUT_LSB     = 16;
   localparam int          GPDR_IN_LSB      = 0;

   // Reset values of stored fields
   localparam logic [4:0]  GPDR_P0_RST      = 5'h00;
   localparam logic [1:0]  GPDR_P1_RST      = 2'h0;

   // Answer to unmapped reads
   localparam logic [31:0] GPDR_UNMAPPED    = 32'h00000000;

   // Bus FSM states, one-hot
   typedef enum logic [1:0] {
      GPDR_IDLE = 2'b01,
      GPDR_DONE = 2'b10
   } gpdr_state_t;

endpackage : gpdr_pkg

/* File: hw/gpdr_port.sv */
// One GPIO port: direction and output storage, pin drive, input sampling.
// Assumes pin inputs are synchronous to sys_clk.
`timescale 1ns/100ps

module gpdr_port #(
   parameter int          PINS = 5,
   parameter logic [31:0] RSTV = 32'h00000000
) (
   // Clock and reset
   input  wire logic            sys_clk,
   input  wire logic            sys_rst,
   // Store strobe and data
   input  wire logic            wr_en,
   input  wire logic [PINS-1:0] wr_dir,
   input  wire logic [PINS-1:0] wr_out,
   // Pins
   input  wire logic [PINS-1:0] pin_in,
   output logic      [PINS-1:0] pin_out,
   output logic      [PINS-1:0] pin_oe,
   // Read back
   output logic      [PINS-1:0] sampled_in,
   output logic      [PINS-1:0] dir_q,
   output logic      [PINS-1:0] out_q
);

   logic [PINS-1:0] dir_reg;
   logic [PINS-1:0] out_reg;
   logic [PINS-1:0] in_reg;

   ////////////////////////////////////////////////////////////////////////
   // Per-pin storage; out value kept while pin is input
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      always_ff @(posedge sys_clk) begin
         if (sys_rst) begin
            dir_reg[i] <= RSTV[i];
            out_reg[i] <= RSTV[i];
         end else if (wr_en) begin
            dir_reg[i] <= wr_dir[i];
            out_reg[i] <= wr_out[i];
         end
      end
      // Input level registered so read data comes from a flop
      always_ff @(posedge sys_clk) begin
         if (sys_rst) begin
            in_reg[i] <= 1'b0;
         end else begin
            in_reg[i] <= pin_in[i];
         end
      end
   end

   // Pin drive straight from flops; enable follows direction
   assign pin_out    = out_reg;
   assign pin_oe     = dir_reg;
   assign sampled_in = in_reg;
   assign dir_q      = dir_reg;
   assign out_q      = out_reg;

endmodule : gpdr_port

/* File: hw/gpdr_top.sv */
// Two GPIO ports (five pins and two pins) behind an Avalon-MM slave.
// Assumes a synchronous active-high reset and pins synchronous to sys_clk.
`timescale 1ns/100ps

module gpdr_top
(
   // Clock and reset
   input  wire logic                           sys_clk,
   input  wire logic                           sys_rst,
   // Avalon-MM slave
   input  wire logic [gpdr_pkg::GPDR_ADDR_W-1:0] avs_address,
   input  wire logic                           avs_read,
   input  wire logic                           avs_write,
   input  wire logic [31:0]                    avs_writedata,
   input  wire logic [3:0]                     avs_byteenable,
   output logic      [31:0]                    avs_readdata,
   output logic                                avs_waitrequest,
   // Port 0 pins
   input  wire logic [gpdr_pkg::GPDR_P0_PINS-1:0] p0_pin_in,
   output logic      [gpdr_pkg::GPDR_P0_PINS-1:0] p0_pin_out,
   output logic      [gpdr_pkg::GPDR_P0_PINS-1:0] p0_pin_oe,
   // Port 1 pins
   input  wire logic [gpdr_pkg::GPDR_P1_PINS-1:0] p1_pin_in,
   output logic      [gpdr_pkg::GPDR_P1_PINS-1:0] p1_pin_out,
   output logic      [gpdr_pkg::GPDR_P1_PINS-1:0] p1_pin_oe
);
   import gpdr_pkg::*;

   gpdr_state_t     state_reg;
   gpdr_state_t     state_next;
   logic [31:0]     rdata_reg;
   logic [31:0]     rdata_next;
   logic            wait_reg;
   wire             req;
   wire             sel0;
   wire             sel1;
   wire             full_we;
   wire             wr0;
   wire             wr1;
   wire [31:0]      word0;
   wire [31:0]      word1;
   logic [4:0]      p0_in;
   logic [4:0]      p0_dir;
   logic [4:0]      p0_out;
   logic [1:0]      p1_in;
   logic [1:0]      p1_dir;
   logic [1:0]      p1_out;

   ////////////////////////////////////////////////////////////////////////
   // Decode; stored fields sit in bytes 2 and 3, so those lanes gate writes
   assign req     = avs_read | avs_write;
   assign sel0    = (avs_address == GPDR_PORT0_IDX);
   assign sel1    = (avs_address == GPDR_PORT1_IDX);
   assign full_we = avs_byteenable[2] & avs_byteenable[3];
   assign wr0     = (state_reg == GPDR_IDLE) & avs_write & sel0 & full_we;
   assign wr1     = (state_reg == GPDR_IDLE) & avs_write & sel1 & full_we;

   // Read words; reserved bits read zero, input bits are registered pin samples
   assign word0 = {3'h0, p0_dir, 3'h0, p0_out, 11'h000, p0_in};
   assign word1 = {6'h00, p1_dir, 6'h00, p1_out, 14'h0000, p1_in};

   ////////////////////////////////////////////////////////////////////////
   // Port instances
   gpdr_port #(.PINS(GPDR_P0_PINS), .RSTV({27'h0, GPDR_P0_RST})) u_p0 (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .wr_en      (wr0),
      .wr_dir     (avs_writedata[GPDR_DIR_LSB +: GPDR_P0_PINS]),
      .wr_out     (avs_writedata[GPDR_OUT_LSB +: GPDR_P0_PINS]),
      .pin_in     (p0_pin_in),
      .pin_out    (p0_pin_out),
      .pin_oe     (p0_pin_oe),
      .sampled_in (p0_in),
      .dir_q      (p0_dir),
      .out_q      (p0_out)
   );

   gpdr_port #(.PINS(GPDR_P1_PINS), .RSTV({30'h0, GPDR_P1_RST})) u_p1 (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .wr_en      (wr1),
      .wr_dir     (avs_writedata[GPDR_DIR_LSB +: GPDR_P1_PINS]),
      .wr_out     (avs_writedata[GPDR_OUT_LSB +: GPDR_P1_PINS]),
      .pin_in     (p1_pin_in),
      .pin_out    (p1_pin_out),
      .pin_oe     (p1_pin_oe),
      .sampled_in (p1_in),
      .dir_q      (p1_dir),
      .out_q      (p1_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, then answer; keeps readdata a flop
   always_comb begin
      state_next = state_reg;
      rdata_next = rdata_reg;
      unique case (state_reg)
         GPDR_IDLE: begin
            if (req) begin
               state_next = GPDR_DONE;
               rdata_next = sel0 ? word0 : (sel1 ? word1 : GPDR_UNMAPPED);
            end
         end
         GPDR_DONE: begin
            state_next = GPDR_IDLE;
         end
         default: begin
            state_next = GPDR_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_reg <= GPDR_IDLE;
         rdata_reg <= 32'h00000000;
         wait_reg  <= 1'b1;
      end else begin
         state_reg <= state_next;
         rdata_reg <= rdata_next;
         wait_reg  <= ~(state_reg == GPDR_IDLE && req);
      end
   end

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // A store; data need not match the cycle before, the master sets both
   sequence s_wr0;
      wr0;
   endsequence

   // Handshake steps: a taken request, then exactly one answer cycle
   sequence s_take;
      state_reg == GPDR_IDLE && req;
   endsequence

   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   a_p0_dir_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_wr0 |=> p0_pin_oe == $past(avs_writedata[28:24]))
      else $error("port0 direction not stored");
   a_p0_out_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr0 |=> p0_pin_out == $past(avs_writedata[20:16]))
      else $error("port0 output not driven");
   a_p0_in_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state_reg == GPDR_IDLE && req && sel0) |=>
      avs_readdata[4:0] == $past(p0_in))
      else $error("port0 input bits wrong");
   a_p1_dir_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr1 |=> p1_pin_oe == $past(avs_writedata[25:24]))
      else $error("port1 direction not stored");
   a_p1_out_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr1 |=> p1_pin_out == $past(avs_writedata[17:16]))
      else $error("port1 output not driven");
   a_p1_in_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state_reg == GPDR_IDLE && req && sel1) |=>
      avs_readdata == {6'h00, $past(p1_dir), 6'h00, $past(p1_out),
                       14'h0000, $past(p1_in)})
      else $error("port1 read word wrong");
   a_word_layout: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state_reg == GPDR_IDLE && req && sel0) |=>
      avs_readdata[31:29] == 3'h0 && avs_readdata[15:5] == 11'h000)
      else $error("port0 reserved bits not zero");
   a_hold_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!wr0 && p0_pin_oe == 5'h00) |=> $stable(p0_pin_out))
      else $error("stored output lost while input");
   a_wait_once: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_take |=> s_answer)
      else $error("waitrequest handshake wrong");

   // Direction and outputs move only on a store
   a_p0_oe_kept: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !wr0 |=> $stable(p0_pin_oe))
      else $error("port0 direction moved without store");
   a_p1_oe_kept: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !wr1 |=> $stable(p1_pin_oe))
      else $error("port1 direction moved without store");
   a_p1_hold_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!wr1 && p1_pin_oe == 2'h0) |=> $stable(p1_pin_out))
      else $error("port1 stored output lost while input");

   // Partial-lane and unmapped writes store nothing
   a_part_refused: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      (avs_write && (!full_we || (!sel0 && !sel1))) |=>
      $stable(p0_pin_oe) && $stable(p0_pin_out) &&
      $stable(p1_pin_oe) && $stable(p1_pin_out))
      else $error("refused write changed a port");

   // Read words: unmapped zero, reserved zero, data stands between takes
   a_unmapped_zero: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      (state_reg == GPDR_IDLE && req && !sel0 && !sel1) |=>
      avs_readdata == GPDR_UNMAPPED)
      else $error("unmapped read not zero");
   a_p1_reserved: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state_reg == GPDR_IDLE && req && sel1) |=>
      avs_readdata[31:26] == 6'h00 && avs_readdata[23:18] == 6'h00 &&
      avs_readdata[15:2] == 14'h0000)
      else $error("port1 reserved bits not zero");
   a_rdata_stands: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      !(state_reg == GPDR_IDLE && req) |=> $stable(avs_readdata))
      else $error("read data moved without request");

   // Leaving reset: idle handshake and every pin an input
   a_rst_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $fell(sys_rst) |->
      avs_waitrequest && p0_pin_oe == 5'h00 && p1_pin_oe == 2'h0)
      else $error("state after reset wrong");

endmodule : gpdr_top

/* File: bench/gpdr_top_test.sv */
// Self-checking bench for the two-port GPIO data/direction block.
// Assumes gpdr_pkg and gpdr_top are compiled first; bench drives all pins.
`timescale 1ns/100ps

`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
   failures++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end

module gpdr_top_test;
   import gpdr_pkg::*;
   logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic [2:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable;
   logic [4:0]  p0_pin_in, p0_pin_out, p0_pin_oe, ext0;
   logic [1:0]  p1_pin_in, p1_pin_out, p1_pin_oe, ext1;
   int          failures, tests_run;
   ////////////////////////////////////////////////////////////////////////
   // Wire level: driven value where enabled, outside level elsewhere
   assign p0_pin_in = (p0_pin_oe & p0_pin_out) | (~p0_pin_oe & ext0);
   assign p1_pin_in = (p1_pin_oe & p1_pin_out) | (~p1_pin_oe & ext1);

   gpdr_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .p0_pin_in(p0_pin_in),
      .p0_pin_out(p0_pin_out), .p0_pin_oe(p0_pin_oe),
      .p1_pin_in(p1_pin_in), .p1_pin_out(p1_pin_out),
      .p1_pin_oe(p1_pin_oe));

   // 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   // One Avalon cycle; held until waitrequest seen low, bounded wait
   task automatic bus(input logic w, input logic [2:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int n;
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= w;
      avs_read       <= ~w;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 50) begin
         failures++;
         complete_run();
      end
      @(posedge sys_clk);
   endtask : bus

   task automatic wr(input logic [2:0] a, input logic [31:0] d,
                     input logic [3:0] be);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
   endtask : wr

   task automatic rd(input string nm, input logic [2:0] a,
                     input logic [31:0] ex);
      logic [31:0] q;
      repeat (2) @(posedge sys_clk); // Pin level is registered once
      bus(1'b0, a, 32'h00000000, 4'hF, q);
      `CHK(nm, ex, q)
   endtask : rd

   function automatic logic [31:0] wd(logic [7:0] d, logic [7:0] o,
                                      logic [7:0] i);
      return {d, o, 8'h00, i};
   endfunction : wd
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      `CHK("oe0", 5'h00, p0_pin_oe)
      `CHK("oe1", 2'h0, p1_pin_oe)
      `CHK("out0", 5'h00, p0_pin_out)
      `CHK("out1", 2'h0, p1_pin_out)
      ext0 <= 5'h0B;
      ext1 <= 2'h2;
      rd("rst0", GPDR_PORT0_IDX, wd(8'h00, 8'h00, 8'h0B));
      rd("rst1", GPDR_PORT1_IDX, wd(8'h00, 8'h00, 8'h02));
   endtask : t_reset

   // Clean writes: reserved and input bits zero
   task automatic t_port0;
      wr(GPDR_PORT0_IDX, wd(8'h15, 8'h0A, 8'h00), 4'hF);
      `CHK("p0oe", 5'h15, p0_pin_oe)
      `CHK("p0out", 5'h0A, p0_pin_out)
      `CHK("p1oe", 2'h0, p1_pin_oe)
      ext0 <= 5'h1F;
      rd("p0rd", GPDR_PORT0_IDX, wd(8'h15, 8'h0A, 8'h0A));
   endtask : t_port0

   // Input bits written as ones must be ignored
   task automatic t_port1;
      wr(GPDR_PORT1_IDX, wd(8'h02, 8'h03, 8'h03), 4'hF);
      `CHK("p1oe", 2'h2, p1_pin_oe)
      `CHK("p1out", 2'h3, p1_pin_out)
      ext1 <= 2'h0;
      rd("p1rd", GPDR_PORT1_IDX, wd(8'h02, 8'h03, 8'h02));
      rd("p0kept", GPDR_PORT0_IDX, wd(8'h15, 8'h0A, 8'h0A));
   endtask : t_port1

   task automatic t_hold;
      wr(GPDR_PORT0_IDX, wd(8'h00, 8'h1F, 8'h00), 4'hF);
      `CHK("hold_oe", 5'h00, p0_pin_oe)
      ext0 <= 5'h00;
      rd("hold_rd", GPDR_PORT0_IDX, wd(8'h00, 8'h1F, 8'h00));
      wr(GPDR_PORT0_IDX, wd(8'h1F, 8'h1F, 8'h00), 4'hF);
      `CHK("drv_oe", 5'h1F, p0_pin_oe)
      `CHK("drv_out", 5'h1F, p0_pin_out)
   endtask : t_hold

   // Partial lanes and unmapped index store nothing
   task automatic t_refuse;
      wr(GPDR_PORT0_IDX, wd(8'h00, 8'h00, 8'h00), 4'h3);
      wr(3'h1, wd(8'h00, 8'h00, 8'h00), 4'hF);
      rd("unmap", 3'h1, GPDR_UNMAPPED);
      rd("kept", GPDR_PORT0_IDX, wd(8'h1F, 8'h1F, 8'h1F));
   endtask : t_refuse

   // Reset in mid-run clears stored fields and idles the handshake
   task automatic t_rerun;
      wr(GPDR_PORT1_IDX, wd(8'h03, 8'h01, 8'h00), 4'hF);
      sys_rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      `CHK("rr_oe0", 5'h00, p0_pin_oe)
      `CHK("rr_out0", 5'h00, p0_pin_out)
      `CHK("rr_oe1", 2'h0, p1_pin_oe)
      `CHK("rr_out1", 2'h0, p1_pin_out)
      `CHK("rr_wait", 1'b1, avs_waitrequest)
      rd("rr_rd1", GPDR_PORT1_IDX, wd(8'h00, 8'h00, 8'h00));
   endtask : t_rerun
   ////////////////////////////////////////////////////////////////////////
   initial begin
      failures = 0;
      tests_run = 0;
      sys_rst = 1'b1;
      {avs_read, avs_write} = 2'b00;
      avs_address = 3'h0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
      ext0 = 5'h00;
      ext1 = 2'h0;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_port0();
      t_port1();
      t_hold();
      t_refuse();
      t_rerun();
      complete_run();
   end
endmodule : gpdr_top_test
